/* hdl/standby_mode_controller.sv */
// Standby and CPU-halt mode controller with APB register access
`timescale 1ns/100ps
module standby_mode_controller #(
  parameter int WU_FAST_LONG = 196608,
  parameter int WU_FAST_MID = 65536,
  parameter int WU_FAST_SHORT = 49152,
  parameter int WU_FAST_MIN = 16384,
  parameter int WU_SLOW_LONG = 24576,
  parameter int WU_SLOW_MID = 8192
) (
  // Clock and reset pin
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Release pins and oscillator ticks
  input wire logic stop_pin_port_bit,
  input wire logic [3:0] key_wakeup_inputs,
  input wire logic hf_osc_tick,
  input wire logic lf_osc_tick,
  // Interrupt status from the core
  input wire logic interrupt_master_enable,
  input wire logic [7:0] interrupt_latch,
  input wire logic [7:0] interrupt_enable_flag,
  input wire logic watchdog_irq,
  // Mode outputs
  output logic cpu_stop,
  output logic watchdog_stop,
  output logic periph_stop,
  output logic hf_osc_enable,
  output logic lf_osc_enable,
  output logic slow_clock_select,
  output logic prescaler_clear,
  output logic port_output_enable,
  output logic stop_pin_oe_allow,
  output logic resume_next,
  output logic service_request
);

  // Register copy of every piece of state
  typedef struct packed {
    // Mode and standby control
    standby_pkg::state_t state;
    logic start;
    logic release_method_select;
    logic release_method_select_eff;
    logic return_mode_select;
    logic hold;
    logic [1:0] warmup_time_select;
    // Key wake-up enables
    logic [3:0] key_en;
    // Clock mode control
    logic xen;
    logic xten;
    logic sysck;
    logic halt;
    // Warm-up bookkeeping
    logic dual;
    logic [17:0] count;
    // Stop pin history
    logic stop_q;
    // Bus response
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    // Registered mode outputs
    logic cpu_stop;
    logic periph_stop;
    logic presc_clear;
    logic port_oe;
    logic stop_oe;
    logic resume;
    logic service;
  } regs_t;

  // Warm-up count type
  typedef logic [17:0] cnt_t;

  regs_t r;
  regs_t next_r;

  // Bus decode
  logic [7:0] idx;
  logic setup;
  logic wr;
  logic [7:0] wdat;
  // Release conditions
  logic rise;
  logic level_cond;
  logic irq_any;
  // Warm-up length for the current settings
  cnt_t wu_load;

  // Bus decode
  assign idx = paddr[standby_pkg::ADDR_LSB +: 8];
  assign setup = psel & ~penable;
  assign wr = psel & penable & r.pready & pwrite;
  assign wdat = pwdata[7:0];

  // Release conditions seen on the raw pins
  assign rise = stop_pin_port_bit & ~r.stop_q;
  assign level_cond = stop_pin_port_bit | (|(r.key_en & ~key_wakeup_inputs));
  // Any enabled pending interrupt
  assign irq_any = |(interrupt_latch & interrupt_enable_flag);

  // Warm-up length per select code and return mode
  always_comb begin
    wu_load = '0;
    if (r.return_mode_select) begin
      // Slow return counts low-frequency ticks
      unique case (r.warmup_time_select)
        standby_pkg::WUT_LONG: begin
          wu_load = cnt_t'(WU_SLOW_LONG);
        end
        standby_pkg::WUT_MID: begin
          wu_load = cnt_t'(WU_SLOW_MID);
        end
        standby_pkg::WUT_SHORT: begin
          wu_load = standby_pkg::WU_SLOW_SHORT;
        end
        standby_pkg::WUT_MIN: begin
          wu_load = standby_pkg::WU_SLOW_MIN;
        end
      endcase
    end else begin
      // Fast return counts high-frequency ticks
      unique case (r.warmup_time_select)
        standby_pkg::WUT_LONG: begin
          wu_load = cnt_t'(WU_FAST_LONG);
        end
        standby_pkg::WUT_MID: begin
          wu_load = cnt_t'(WU_FAST_MID);
        end
        standby_pkg::WUT_SHORT: begin
          wu_load = cnt_t'(WU_FAST_SHORT);
        end
        standby_pkg::WUT_MIN: begin
          wu_load = cnt_t'(WU_FAST_MIN);
        end
      endcase
    end
  end

  // Next-state logic for all state
  always_comb begin
    next_r = r;
    // Stop pin history runs on the always-on clock
    next_r.stop_q = stop_pin_port_bit;
    // Single-cycle pulses default low
    next_r.resume = 1'b0;
    next_r.service = 1'b0;
    next_r.presc_clear = 1'b0;
    // No wait state: ready in the first access cycle
    next_r.pslverr = 1'b0;
    next_r.pready = setup;
    next_r.prdata = '0;

    // Read data captured in the setup cycle
    if (setup) begin
      unique case (idx)
        standby_pkg::IDX_STANDBY_CTRL: begin
          next_r.prdata[7:0] = {r.start, r.release_method_select, r.return_mode_select, r.hold, r.warmup_time_select, 2'b00};
        end
        standby_pkg::IDX_CLOCK_MODE: begin
          next_r.prdata[7:0] = {r.xen, r.xten, r.sysck, r.halt, 4'h0};
        end
        standby_pkg::IDX_KEY_WAKEUP: begin
          next_r.prdata[3:0] = r.key_en;
        end
        standby_pkg::IDX_STATUS: begin
          next_r.prdata[3:0] = {r.release_method_select_eff, r.state};
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end

    // Effective release method follows the stop pin edge
    if (!r.release_method_select) begin
      next_r.release_method_select_eff = 1'b0;
    end else if (!r.release_method_select_eff && rise) begin
      next_r.release_method_select_eff = 1'b1;
    end

    // Mode sequencer
    unique case (r.state)
      standby_pkg::ST_RUN: begin
        if (wr && idx == standby_pkg::IDX_STANDBY_CTRL) begin
          // Standby control fields
          next_r.release_method_select = wdat[standby_pkg::BIT_RELEASE_METHOD_SELECT];
          next_r.return_mode_select = wdat[standby_pkg::BIT_RETURN_MODE_SELECT];
          next_r.hold = wdat[standby_pkg::BIT_HOLD];
          next_r.warmup_time_select = wdat[standby_pkg::BIT_WUT_HI:standby_pkg::BIT_WUT_LO];
          if (wdat[standby_pkg::BIT_START]) begin
            next_r.start = 1'b1;
            next_r.dual = r.xen & r.xten;
            next_r.presc_clear = 1'b1;
            if (r.release_method_select_eff && wdat[standby_pkg::BIT_RELEASE_METHOD_SELECT] && level_cond) begin
              next_r.state = standby_pkg::ST_WARMUP;
            end else begin
              next_r.state = standby_pkg::ST_STANDBY;
            end
          end
        end else if (wr && idx == standby_pkg::IDX_CLOCK_MODE) begin
          // Clock mode fields
          next_r.xen = wdat[standby_pkg::BIT_XEN];
          next_r.xten = wdat[standby_pkg::BIT_XTEN];
          next_r.sysck = wdat[standby_pkg::BIT_SYSCK];
          if (wdat[standby_pkg::BIT_HALT]) begin
            if (watchdog_irq) begin
              next_r.service = 1'b1;
            end else begin
              next_r.halt = 1'b1;
              next_r.state = standby_pkg::ST_HALT;
            end
          end
        end else if (wr && idx == standby_pkg::IDX_KEY_WAKEUP) begin
          next_r.key_en = wdat[standby_pkg::KEY_W-1:0];
        end
      end
      standby_pkg::ST_STANDBY: begin
        // Oscillators off; stored state untouched
        next_r.xen = 1'b0;
        next_r.xten = 1'b0;
        // Level or edge release per effective method
        if (r.release_method_select_eff ? level_cond : rise) begin
          next_r.state = standby_pkg::ST_WARMUP;
        end
      end
      standby_pkg::ST_WARMUP: begin
        // Restart oscillators for the return mode
        next_r.xen = ~r.return_mode_select;
        next_r.xten = r.return_mode_select | r.dual;
        next_r.sysck = r.return_mode_select;
        // Count selected oscillator ticks down to the last one
        if (r.return_mode_select ? lf_osc_tick : hf_osc_tick) begin
          if (r.count == cnt_t'(1)) begin
            next_r.state = standby_pkg::ST_RUN;
            next_r.start = 1'b0;
            next_r.resume = 1'b1;
          end else begin
            next_r.count = r.count - cnt_t'(1);
          end
        end
      end
      standby_pkg::ST_HALT: begin
        // Any enabled interrupt ends the halt
        if (irq_any) begin
          next_r.halt = 1'b0;
          next_r.state = standby_pkg::ST_RUN;
          next_r.resume = 1'b1;
          // Service wanted only with master enable set
          next_r.service = interrupt_master_enable;
        end
      end
      default: begin
        next_r.state = standby_pkg::ST_RUN;
      end
    endcase

    // Load the warm-up length on entry only
    if (next_r.state == standby_pkg::ST_WARMUP && r.state != standby_pkg::ST_WARMUP) begin
      next_r.count = wu_load;
    end
    // Output levels follow the next mode
    next_r.cpu_stop = next_r.state != standby_pkg::ST_RUN;
    next_r.periph_stop = next_r.state == standby_pkg::ST_STANDBY || next_r.state == standby_pkg::ST_WARMUP;
    // Port drive during standby
    next_r.port_oe = !(next_r.state == standby_pkg::ST_STANDBY && !next_r.hold);
    next_r.stop_oe = next_r.state != standby_pkg::ST_STANDBY;
  end

  // State register; reset pin returns single-clock fast run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      // Oscillator and port drive defaults
      r.xen <= standby_pkg::RST_CLOCK_MODE[standby_pkg::BIT_XEN];
      r.port_oe <= 1'b1;
      r.stop_oe <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Bus outputs straight from the state register
  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;

  // Mode outputs
  assign cpu_stop = r.cpu_stop;
  assign watchdog_stop = r.cpu_stop;
  assign periph_stop = r.periph_stop;

  // Oscillator and clock controls
  assign hf_osc_enable = r.xen;
  assign lf_osc_enable = r.xten;
  assign slow_clock_select = r.sysck;

  // Port drive and pulses
  assign prescaler_clear = r.presc_clear;
  assign port_output_enable = r.port_oe;
  assign stop_pin_oe_allow = r.stop_oe;
  assign resume_next = r.resume;
  assign service_request = r.service;

endmodule : standby_mode_controller

/* hdl/standby_pkg.sv */
// Constants and types for the standby mode controller
package standby_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_STANDBY_CTRL = 8'h38;
  localparam logic [7:0] IDX_CLOCK_MODE = 8'h39;
  localparam logic [7:0] IDX_KEY_WAKEUP = 8'h3A;
  localparam logic [7:0] IDX_STATUS = 8'h3B;
  localparam int ADDR_LSB = 2;
  // Standby control field positions
  localparam int BIT_START = 7;
  localparam int BIT_RELEASE_METHOD_SELECT = 6;
  localparam int BIT_RETURN_MODE_SELECT = 5;
  localparam int BIT_HOLD = 4;
  localparam int BIT_WUT_HI = 3;
  localparam int BIT_WUT_LO = 2;
  // Clock mode control field positions
  localparam int BIT_XEN = 7;
  localparam int BIT_XTEN = 6;
  localparam int BIT_SYSCK = 5;
  localparam int BIT_HALT = 4;
  // Key wake-up width and warm-up counter width
  localparam int KEY_W = 4;
  localparam int CNT_W = 18;
  // Reset values
  localparam logic [7:0] RST_STANDBY_CTRL = 8'h00;
  localparam logic [7:0] RST_CLOCK_MODE = 8'h80;
  localparam logic [3:0] RST_KEY_WAKEUP = 4'h0;
  // Warm-up codes
  localparam logic [1:0] WUT_LONG = 2'b00;
  localparam logic [1:0] WUT_MID = 2'b01;
  localparam logic [1:0] WUT_SHORT = 2'b10;
  localparam logic [1:0] WUT_MIN = 2'b11;
  // Short slow warm-up counts in low-frequency clocks
  localparam logic [17:0] WU_SLOW_SHORT = 18'h0_00C0;
  localparam logic [17:0] WU_SLOW_MIN = 18'h0_0040;
  // Mode states
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STANDBY = 3'b001,
    ST_WARMUP = 3'b010,
    ST_HALT = 3'b011
  } state_t;
endpackage : standby_pkg

/* sim/osc_model.sv */
// Oscillator model giving tick pulses while enabled
`timescale 1ns/100ps
module osc_model #(
  parameter int HF_DIV = 8,
  parameter int LF_DIV = 2
) (
  // Clock and enables
  input wire logic pclk,
  input wire logic hf_en,
  input wire logic lf_en,
  // Tick pulses
  output logic hf_tick,
  output logic lf_tick
);
  int cnt = 0;
  // Free-running divider; a stopped oscillator gives no ticks
  always @(posedge pclk) begin
    cnt <= cnt + 1;
    hf_tick <= hf_en && (cnt % HF_DIV == 0);
    lf_tick <= lf_en && (cnt % LF_DIV == 0);
  end
endmodule : osc_model

/* sim/standby_checker_assertions.sv */
// Port-level checker for the standby mode controller
`timescale 1ns/100ps
module standby_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Interrupt status
  input wire logic interrupt_master_enable,
  input wire logic [7:0] interrupt_latch,
  input wire logic [7:0] interrupt_enable_flag,
  // Mode outputs
  input wire logic cpu_stop,
  input wire logic watchdog_stop,
  input wire logic periph_stop,
  input wire logic port_output_enable,
  input wire logic stop_pin_oe_allow,
  input wire logic resume_next,
  input wire logic service_request,
  input wire logic prescaler_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wake;
  // Halt state seen with a pending enabled interrupt
  assign wake = cpu_stop && !periph_stop && |(interrupt_latch & interrupt_enable_flag);
  a_pready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_standby_halts_cpu: assert property (periph_stop |-> cpu_stop && watchdog_stop)
    else $error("peripherals stopped while cpu runs");
  a_stop_pin_float: assert property (!stop_pin_oe_allow |-> periph_stop)
    else $error("stop pin released outside standby");
  a_hold_only_standby: assert property (!port_output_enable |-> !stop_pin_oe_allow)
    else $error("ports floated outside standby");
  a_halt_release: assert property (wake |-> ##[1:2] !cpu_stop)
    else $error("halt not released by enabled interrupt");
  a_halt_service: assert property (wake && interrupt_master_enable |-> ##[1:2] service_request)
    else $error("no service request on halt release");
  a_resume_pulse: assert property (resume_next |=> !resume_next)
    else $error("resume pulse too long");
  a_clear_pulse: assert property (prescaler_clear |=> !prescaler_clear)
    else $error("prescaler clear pulse too long");
endmodule : standby_checker
bind standby_mode_controller standby_checker standby_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .interrupt_master_enable(interrupt_master_enable), .interrupt_latch(interrupt_latch),
  .interrupt_enable_flag(interrupt_enable_flag), .cpu_stop(cpu_stop), .watchdog_stop(watchdog_stop),
  .periph_stop(periph_stop), .port_output_enable(port_output_enable), .stop_pin_oe_allow(stop_pin_oe_allow),
  .resume_next(resume_next), .service_request(service_request), .prescaler_clear(prescaler_clear)
);

/* sim/standby_mode_controller_test.sv */
// Register-level testbench for the standby mode controller
`timescale 1ns/100ps
module standby_mode_controller_test;
  localparam logic [31:0] A_CTL = 32'h0000_00E0, A_CLK = 32'h0000_00E4, A_KEY = 32'h0000_00E8;
  localparam logic [31:0] A_ST = 32'h0000_00EC, A_BAD = 32'h0000_00F0;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rdv;
  logic pready, pslverr, err, stp = 1'b0, ime = 1'b0, wdg = 1'b0, svc = 1'b0, pcs = 1'b0, sck, pclr;
  logic [3:0] keys = 4'hF;
  logic [7:0] lat = 8'h00, ena = 8'h00;
  logic hf_t, lf_t, hf_en, lf_en, cpu_stop, wd_stop, per_stop, poe, soe, rnext, sreq;
  int n_fail = 0, comparisons = 0, cyc = 0, n_hf = 0, hf_rs = 0, hf_res = 0;
  int wu[4] = '{8, 6, 5, 4};
  standby_mode_controller #(.WU_FAST_LONG(8), .WU_FAST_MID(6), .WU_FAST_SHORT(5), .WU_FAST_MIN(4),
    .WU_SLOW_LONG(3)) standby_mode_controller_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .stop_pin_port_bit(stp),
    .key_wakeup_inputs(keys), .hf_osc_tick(hf_t), .lf_osc_tick(lf_t), .interrupt_master_enable(ime),
    .interrupt_latch(lat), .interrupt_enable_flag(ena), .watchdog_irq(wdg), .cpu_stop(cpu_stop),
    .watchdog_stop(wd_stop), .periph_stop(per_stop), .hf_osc_enable(hf_en), .lf_osc_enable(lf_en),
    .slow_clock_select(sck), .prescaler_clear(pclr), .port_output_enable(poe), .stop_pin_oe_allow(soe),
    .resume_next(rnext), .service_request(sreq));
  osc_model osc_model_inst (.pclk(pclk), .hf_en(hf_en), .lf_en(lf_en), .hf_tick(hf_t), .lf_tick(lf_t));
  always #4 pclk = ~pclk;
  // Tick count, tick count at resume, sticky service flag, hang limit
  always @(posedge pclk) begin
    n_hf <= n_hf + (hf_t === 1'b1);
    if (rnext) hf_res <= n_hf;
    if (sreq) svc <= 1'b1;
    if (pclr) pcs <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task summarize();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Pready read as it stood at each rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdv, e);
  endtask : rd
  task wait_st(input logic [2:0] s);
    int k;
    k = 0;
    do begin
      xfer(1'b0, A_ST, 32'h0000_0000);
      k++;
    end while (rdv[2:0] !== s && k < 300);
    chk(rdv[2:0], s);
  endtask : wait_st
  task halt_case(input logic m, input logic w, input logic s);
    @(posedge pclk);
    ime <= m;
    wdg <= w;
    ena <= 8'h04;
    svc = 1'b0;
    xfer(1'b1, A_CLK, 32'h0000_0090);
    if (!w) begin
      wait_st(3'h3);
      chk({cpu_stop, wd_stop, per_stop}, 3'b110);
      @(posedge pclk) lat <= 8'h04;
    end
    wait_st(3'h0);
    rd(A_CLK, 32'h0000_0080);
    chk(svc, s);
    lat <= 8'h00;
    wdg <= 1'b0;
  endtask : halt_case
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CLK, 32'h0000_0080);
    rd(A_CTL, 32'h0000_0000);
    rd(A_BAD, 32'h0000_0000);
    chk(err, 1'b1);
    halt_case(1'b0, 1'b0, 1'b0);
    halt_case(1'b1, 1'b0, 1'b1);
    halt_case(1'b0, 1'b1, 1'b1);
    xfer(1'b1, A_KEY, 32'h0000_0001);
    rd(A_KEY, 32'h0000_0001);
    ime <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      stp <= 1'b1;
      pcs = 1'b0;
      xfer(1'b1, A_CTL, 32'h0000_0080 | (c << 2));
      wait_st(3'h1);
      chk(pcs, 1'b1);
      chk({poe, soe, per_stop}, 3'b001);
      @(posedge pclk) stp <= 1'b0;
      repeat (4) @(posedge pclk);
      stp <= 1'b1;
      hf_rs = n_hf;
      wait_st(3'h0);
      chk((hf_res - hf_rs) inside {[wu[c] - 1 : wu[c] + 1]}, 1'b1);
      rd(A_CTL, c << 2);
    end
    stp <= 1'b0;
    xfer(1'b1, A_CTL, 32'h0000_0040);
    rd(A_ST, 32'h0000_0000);
    stp <= 1'b1;
    rd(A_ST, 32'h0000_0008);
    xfer(1'b1, A_CTL, 32'h0000_00CC);
    rd(A_ST, 32'h0000_000A);
    stp <= 1'b0;
    wait_st(3'h0);
    xfer(1'b1, A_CTL, 32'h0000_00EC);
    wait_st(3'h1);
    keys <= 4'hE;
    wait_st(3'h0);
    chk(lf_en, 1'b1);
    chk(sck, 1'b1);
    keys <= 4'hF;
    xfer(1'b1, A_CTL, 32'h0000_0080);
    wait_st(3'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_ST, 32'h0000_0000);
    rd(A_CLK, 32'h0000_0080);
    summarize();
  end
endmodule : standby_mode_controller_test
